//--- rtl/ppio_handshake.sv
/*
  Parallel I/O handshake of a point-to-point positioner with an AHB-Lite
  register slave. Assumes host pins are asynchronous, the motion core runs
  on clk_i, and the bus master issues single word transfers only.
*/
// Implementation choices: register access over AHB-Lite and the address map.
// Function
// - after power-up, raise position-complete once the controller is ready
// - start drops position-complete; move finish raises it again
// - completed-position code clears together with position-complete
// - completed-position code stays zero during emergency stop or teaching
// - on return to ready, show last position only when inside the band
// - push-and-hold mode keeps the code zero after stop or teaching
// - moving output follows actual actuator motion, also during pause
// - emergency-stop status high normally, low while stop is actuated
// - servo energised exactly while servo-on input is high
// - reset rising edge clears alarm; persisting cause raises it again
// - overcurrent alarm survives reset input; only power-up clears it
// - reset while paused discards remaining travel
// - start begins a move to the selected command position
// - command position is 4-bit binary, positions zero to fifteen
// - start on a position without data: no move, raise alarm
// - alarm status high normally, low while any alarm is active
// - home-complete set by first home return, held until power-off
`timescale 1ns/100ps

module ppio_handshake
  import ppio_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // host pins
  input wire ppio_pin_in_s pin_i,
  output ppio_pin_out_s pin_o,
  // motion core
  input wire ppio_mot_in_s mot_i,
  output ppio_mot_out_s mot_o
);

  // ==========================================================================
  // pin synchroniser and debounce
  logic [PPIO_PIN_IN_NUM-1:0] pin_raw;
  logic [PPIO_PIN_IN_NUM-1:0] pin_s1_reg;
  logic [PPIO_PIN_IN_NUM-1:0] pin_s2_reg;
  logic [PPIO_PIN_IN_NUM-1:0] pin_s3_reg;
  logic [PPIO_PIN_IN_NUM-1:0] pin_db_reg;
  ppio_pin_in_s pin_db;
  logic start_q_reg;
  logic areset_q_reg;
  logic start_rise;
  logic areset_rise;

  assign pin_raw = pin_i;

  // a change counts only once stages two and three agree
  generate
    for (genvar gi = 0; gi < PPIO_PIN_IN_NUM; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_db_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_db_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  assign pin_db = pin_db_reg;

  // edge detection on the debounced levels only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q_reg <= 1'b0;
      areset_q_reg <= 1'b0;
    end else begin
      start_q_reg <= pin_db.start;
      areset_q_reg <= pin_db.alarm_reset;
    end
  end

  assign start_rise = pin_db.start & ~start_q_reg;
  assign areset_rise = pin_db.alarm_reset & ~areset_q_reg;

  // ==========================================================================
  // software registers
  logic [15:0] pos_valid_reg;
  logic push_mode_reg;
  logic addr_ph_reg;
  logic wr_ph_reg;
  logic [7:0] addr_q_reg;
  logic bus_take;

  assign bus_take = hsel_i & hready_i & htrans_i[1];

  // address phase captured, write data applied in the data phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ph_reg <= 1'b0;
      wr_ph_reg <= 1'b0;
      addr_q_reg <= 8'h00;
    end else begin
      addr_ph_reg <= bus_take;
      wr_ph_reg <= bus_take & hwrite_i;
      if (bus_take) begin
        addr_q_reg <= haddr_i;
      end
    end
  end

  // writable registers; other offsets ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_valid_reg <= PPIO_RST_POS_VALID;
      push_mode_reg <= PPIO_RST_PUSH_MODE;
    end else if (wr_ph_reg) begin
      if (addr_q_reg == PPIO_OFS_POS_VALID) begin
        pos_valid_reg <= hwdata_i[15:0];
      end
      if (addr_q_reg == PPIO_OFS_CTRL) begin
        push_mode_reg <= hwdata_i[PPIO_CTRL_PUSH_BIT];
      end
    end
  end

  // ==========================================================================
  // alarm tracking
  logic alarm_reg;
  logic oc_reg;
  logic [11:0] alarm_code_reg;
  logic no_data_evt;
  logic any_alarm;

  assign any_alarm = alarm_reg | oc_reg;

  // set wins over the reset edge, so a lasting cause comes straight back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_reg <= 1'b0;
      alarm_code_reg <= PPIO_ALM_NONE;
    end else if (no_data_evt) begin
      alarm_reg <= 1'b1;
      alarm_code_reg <= PPIO_ALM_NO_DATA;
    end else if (mot_i.fault) begin
      alarm_reg <= 1'b1;
      alarm_code_reg <= mot_i.fault_code;
    end else if (areset_rise) begin
      alarm_reg <= 1'b0;
      alarm_code_reg <= oc_reg ? PPIO_ALM_OVERCURRENT : PPIO_ALM_NONE;
    end
  end

  // overcurrent is cleared only by power-up reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_reg <= 1'b0;
    end else if (mot_i.overcurrent) begin
      oc_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // handshake state machine
  ppio_state_e state_reg;
  ppio_state_e state_next;
  logic [3:0] target_reg;
  logic [3:0] last_pos_reg;
  logic stop_cond;
  logic start_ok;

  assign stop_cond = mot_i.estop | mot_i.teach;
  assign start_ok = start_rise & pin_db.servo_on & ~any_alarm;
  assign no_data_evt = start_ok & ~pos_valid_reg[pin_db.cmd_pos] & (state_reg == PPIO_ST_READY);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PPIO_ST_INIT: begin
        if (mot_i.ctrl_ready) begin
          state_next = PPIO_ST_READY;
        end
      end
      PPIO_ST_READY: begin
        if (stop_cond) begin
          state_next = PPIO_ST_HOLD;
        end else if (start_ok && pos_valid_reg[pin_db.cmd_pos]) begin
          state_next = PPIO_ST_MOVE;
        end
      end
      PPIO_ST_MOVE: begin
        if (stop_cond) begin
          state_next = PPIO_ST_HOLD;
        end else if (mot_i.move_done) begin
          state_next = PPIO_ST_READY;
        end else if (!pin_db.pause_n) begin
          state_next = PPIO_ST_PAUSE;
        end
      end
      PPIO_ST_PAUSE: begin
        if (stop_cond) begin
          state_next = PPIO_ST_HOLD;
        end else if (areset_rise) begin
          state_next = PPIO_ST_READY;
        end else if (pin_db.pause_n) begin
          state_next = PPIO_ST_MOVE;
        end
      end
      PPIO_ST_HOLD: begin
        if (!stop_cond) begin
          state_next = PPIO_ST_READY;
        end
      end
      default: begin
        state_next = PPIO_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PPIO_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // target latched on the accepted start and frozen for the move
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_reg <= 4'h0;
      last_pos_reg <= 4'h0;
    end else begin
      if (state_reg == PPIO_ST_READY && state_next == PPIO_ST_MOVE) begin
        target_reg <= pin_db.cmd_pos;
      end
      if (state_reg == PPIO_ST_MOVE && state_next == PPIO_ST_READY) begin
        last_pos_reg <= target_reg;
      end
    end
  end

  // ==========================================================================
  // position-complete and completed-position code
  logic pos_complete_reg;
  logic [3:0] done_pos_reg;
  logic moving_reg;
  logic estop_ok_reg;
  logic alarm_ok_reg;
  logic home_reg;

  // both fields change on the same edge so the code never outlives the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_complete_reg <= 1'b0;
      done_pos_reg <= 4'h0;
    end else if (state_next == PPIO_ST_HOLD) begin
      pos_complete_reg <= 1'b0;
      done_pos_reg <= 4'h0;
    end else if (state_next == PPIO_ST_MOVE && state_reg == PPIO_ST_READY) begin
      pos_complete_reg <= 1'b0;
      done_pos_reg <= 4'h0;
    end else if (state_next == PPIO_ST_READY && state_reg != PPIO_ST_READY) begin
      pos_complete_reg <= 1'b1;
      unique case (state_reg)
        PPIO_ST_MOVE: begin
          done_pos_reg <= target_reg;
        end
        PPIO_ST_HOLD: begin
          // push mode gives no code after stop or teaching
          done_pos_reg <= (mot_i.in_band && !push_mode_reg) ? last_pos_reg : 4'h0;
        end
        PPIO_ST_PAUSE: begin
          done_pos_reg <= mot_i.in_band ? last_pos_reg : 4'h0;
        end
        default: begin
          done_pos_reg <= 4'h0;
        end
      endcase
    end
  end

  // status pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      moving_reg <= 1'b0;
      estop_ok_reg <= 1'b0;
      alarm_ok_reg <= 1'b0;
    end else begin
      moving_reg <= mot_i.busy;
      estop_ok_reg <= ~mot_i.estop;
      alarm_ok_reg <= ~(alarm_reg | oc_reg | mot_i.fault | mot_i.overcurrent);
    end
  end

  // home flag survives stops; only power-up clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      home_reg <= 1'b0;
    end else if (mot_i.home_done) begin
      home_reg <= 1'b1;
    end
  end

  assign pin_o = '{pos_complete: pos_complete_reg, done_pos: done_pos_reg,
                   moving: moving_reg, estop_ok: estop_ok_reg,
                   alarm_ok: alarm_ok_reg, home_done: home_reg};

  // ==========================================================================
  // motion core commands
  ppio_mot_out_s mout_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mout_reg <= '0;
    end else begin
      mout_reg.move_start <= (state_reg == PPIO_ST_READY) && (state_next == PPIO_ST_MOVE);
      if (state_reg == PPIO_ST_READY && state_next == PPIO_ST_MOVE) begin
        mout_reg.target <= pin_db.cmd_pos;
      end
      mout_reg.hold <= (state_next == PPIO_ST_PAUSE);
      mout_reg.cancel <= (state_reg == PPIO_ST_PAUSE) && (state_next == PPIO_ST_READY);
      mout_reg.servo_en <= pin_db.servo_on;
    end
  end

  assign mot_o = mout_reg;

  // ==========================================================================
  // bus read data, zero wait states, always OKAY
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (bus_take && !hwrite_i) begin
        unique case (haddr_i)
          PPIO_OFS_POS_VALID: hrdata_o <= {16'h0000, pos_valid_reg};
          PPIO_OFS_CTRL: hrdata_o <= {31'h0000_0000, push_mode_reg};
          PPIO_OFS_STATUS: hrdata_o <= {10'h000, state_reg, last_pos_reg, target_reg, home_reg, oc_reg,
                                         alarm_reg, alarm_ok_reg, estop_ok_reg, moving_reg,
                                         done_pos_reg, pos_complete_reg};
          PPIO_OFS_ALARM: hrdata_o <= {20'h0_0000, alarm_code_reg};
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

//--- include/ppio_pkg.sv
/*
  Shared constants and carriers for the positioner parallel I/O handshake.
  Assumes one 250 MHz clock and a synchronous, active-high reset.
*/
package ppio_pkg;

  // ==========================================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] PPIO_OFS_POS_VALID = 8'h00;
  localparam logic [7:0] PPIO_OFS_CTRL = 8'h04;
  localparam logic [7:0] PPIO_OFS_STATUS = 8'h08;
  localparam logic [7:0] PPIO_OFS_ALARM = 8'h0C;

  // reset values
  localparam logic [15:0] PPIO_RST_POS_VALID = 16'hFFFF;
  localparam logic PPIO_RST_PUSH_MODE = 1'b0;

  // control field positions
  localparam int PPIO_CTRL_PUSH_BIT = 0;

  // alarm codes
  localparam logic [11:0] PPIO_ALM_NONE = 12'h000;
  localparam logic [11:0] PPIO_ALM_NO_DATA = 12'h0B1;
  localparam logic [11:0] PPIO_ALM_OVERCURRENT = 12'h0C8;

  // geometry
  localparam int PPIO_POS_BITS = 4;
  localparam int PPIO_NUM_POS = 16;
  localparam int PPIO_PIN_IN_NUM = 8;

  // ==========================================================================
  // handshake states
  typedef enum logic [2:0] {
    PPIO_ST_INIT  = 3'b000,
    PPIO_ST_READY = 3'b001,
    PPIO_ST_MOVE  = 3'b010,
    PPIO_ST_PAUSE = 3'b011,
    PPIO_ST_HOLD  = 3'b100
  } ppio_state_e;

  // ==========================================================================
  // host-side pins, bit order fixed so they can be synchronised as a vector
  typedef struct packed {
    logic [3:0] cmd_pos;     // weights 8,4,2,1
    logic start;
    logic pause_n;
    logic servo_on;
    logic alarm_reset;
  } ppio_pin_in_s;

  typedef struct packed {
    logic pos_complete;
    logic [3:0] done_pos;
    logic moving;
    logic estop_ok;
    logic alarm_ok;
    logic home_done;
  } ppio_pin_out_s;

  // motion core facing signals, same clock domain
  typedef struct packed {
    logic ctrl_ready;        // core finished power-up
    logic busy;              // actuator physically moving
    logic move_done;         // pulse: commanded move finished
    logic in_band;           // actual position within band of last target
    logic estop;             // emergency stop actuated
    logic teach;             // direct teaching mode
    logic home_done;         // pulse: a home return completed
    logic overcurrent;       // overcurrent cause
    logic fault;             // any other alarm cause
    logic [11:0] fault_code; // its code
  } ppio_mot_in_s;

  typedef struct packed {
    logic move_start;        // pulse: begin move to target
    logic [3:0] target;
    logic hold;              // pause requested
    logic cancel;            // pulse: drop remaining travel
    logic servo_en;
  } ppio_mot_out_s;

endpackage

//--- testbench/ppio_handshake_chk.sv
/*
  Checker for the positioner handshake pins and motion-core outputs.
  Assumes one clock and a synchronous, active-high reset.
*/
`timescale 1ns/100ps

// ==========================================================================
// pin relations
module ppio_handshake_chk
  import ppio_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire ppio_pin_in_s pin_i,
  input wire ppio_pin_out_s pin_o,
  input wire ppio_mot_in_s mot_i,
  input wire ppio_mot_out_s mot_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // three cycles cover the state change plus the output register
  sequence s_stop_held;
    (mot_i.estop || mot_i.teach)[*3];
  endsequence
  sequence s_overcurrent_seen;
    mot_i.overcurrent ##1 1'b1;
  endsequence

  a_stop_clears_code: assert property (s_stop_held |-> pin_o.done_pos == 4'h0 && !pin_o.pos_complete)
    else $error("code shown during stop");
  a_estop_low: assert property (mot_i.estop[*3] |-> !pin_o.estop_ok)
    else $error("stop status high during stop");
  a_estop_high: assert property (!mot_i.estop[*3] |-> pin_o.estop_ok)
    else $error("stop status low without stop");
  a_code_with_complete: assert property (!pin_o.pos_complete |-> pin_o.done_pos == 4'h0)
    else $error("code without position complete");
  a_moving_follows: assert property (mot_i.busy[*2] |-> pin_o.moving)
    else $error("moving low while busy");
  a_servo_follows: assert property (pin_i.servo_on[*8] |-> mot_o.servo_en)
    else $error("servo off while requested");
  a_start_drops: assert property (mot_o.move_start |-> !pin_o.pos_complete)
    else $error("complete high at move start");
  a_target_held: assert property (!mot_o.move_start |-> $stable(mot_o.target))
    else $error("target changed without start");
  a_fault_alarm: assert property (mot_i.fault |=> !pin_o.alarm_ok)
    else $error("alarm status high on fault");
  a_overcurrent_sticks: assert property (s_overcurrent_seen |-> (!pin_o.alarm_ok)[*8])
    else $error("overcurrent alarm cleared");
  a_home_sticks: assert property (pin_o.home_done |=> pin_o.home_done)
    else $error("home complete dropped");
endmodule

bind ppio_handshake ppio_handshake_chk i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .pin_i(pin_i),
  .pin_o(pin_o),
  .mot_i(mot_i),
  .mot_o(mot_o)
);

//--- testbench/ppio_host_model.sv
/*
  Host controller model that drives the parallel input pins.
  Assumes inputs settle within the design's debounce of about 4 edges.
*/
`timescale 1ns/100ps

// ==========================================================================
// host pin driver
module ppio_host_model
  import ppio_pkg::*;
(
  // clock
  input wire logic clk_i,
  // pins towards the positioner
  output ppio_pin_in_s pin_o
);
  // idle: pause released high so motion may run
  initial begin
    pin_o = 8'h04;
  end

  // one pin change, then time for debounce and response
  task automatic put(input ppio_pin_in_s v);
    @(posedge clk_i);
    pin_o <= v;
    repeat (10) @(posedge clk_i);
    #1;
  endtask
endmodule

//--- testbench/tb.sv
/*
  Self-checking bench of the positioner handshake.
  Assumes the bound checker and the host model beside it.
*/
`timescale 1ns/100ps

// ==========================================================================
// bench top
module tb;
  import ppio_pkg::*;
  localparam ppio_mot_in_s M_DONE = '{move_done: 1'b1, default: '0};
  localparam ppio_mot_in_s M_BUSY = '{busy: 1'b1, default: '0};
  localparam ppio_mot_in_s M_STOP = '{estop: 1'b1, default: '0};
  localparam ppio_mot_in_s M_TEACH = '{teach: 1'b1, default: '0};
  localparam ppio_mot_in_s M_BAND = '{in_band: 1'b1, default: '0};
  localparam ppio_mot_in_s M_FAULT = '{fault: 1'b1, default: '0};
  localparam ppio_mot_in_s M_OVER = '{overcurrent: 1'b1, default: '0};
  localparam ppio_mot_in_s M_HOME = '{home_done: 1'b1, default: '0};
  localparam ppio_mot_in_s M_READY = '{ctrl_ready: 1'b1, default: '0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [31:0] r;
  logic hreadyout_o;
  logic hresp_o;
  ppio_pin_in_s pin_i;
  ppio_pin_in_s p = 8'h04;
  ppio_pin_out_s pin_o;
  ppio_mot_in_s mot_i = '0;
  ppio_mot_out_s mot_o;
  int n_errors = 0;
  int n_compared = 0;
  int n_starts = 0;
  int n_cancels = 0;
  int cyc = 0;
  int s0;

  ppio_handshake i_ppio_handshake (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_i(pin_i), .pin_o(pin_o),
    .mot_i(mot_i), .mot_o(mot_o));
  ppio_host_model i_ppio_host_model (.clk_i(clk_i), .pin_o(pin_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // pulse counters and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (mot_o.move_start === 1'b1) n_starts <= n_starts + 1;
    if (mot_o.cancel === 1'b1) n_cancels <= n_cancels + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one ahb-lite single transfer, waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask

  task automatic mset(input ppio_mot_in_s m, input logic on, input int n);
    @(posedge clk_i);
    mot_i <= on ? (mot_i | m) : (mot_i & ~m);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic mpulse(input ppio_mot_in_s m);
    mset(m, 1'b1, 1);
    mset(m, 1'b0, 3);
  endtask

  task automatic reset_pin();
    p.alarm_reset = 1'b1;
    i_ppio_host_model.put(p);
    p.alarm_reset = 1'b0;
    i_ppio_host_model.put(p);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    mot_i <= M_BAND | M_READY;
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  task automatic t_power_up();
    do_reset();
    chk(pin_o.pos_complete, 1'b1);
    chk({pin_o.estop_ok, pin_o.alarm_ok, pin_o.done_pos}, 6'h30);
    bus(1'b0, PPIO_OFS_POS_VALID, 32'h0);
    chk(r, 32'h0000FFFF);
    bus(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    mpulse(M_HOME);
    chk(pin_o.home_done, 1'b1);
    $display("test power_up done");
  endtask

  task automatic t_move();
    p.servo_on = 1'b1;
    i_ppio_host_model.put(p);
    chk(mot_o.servo_en, 1'b1);
    s0 = n_starts;
    p.cmd_pos = 4'hA;
    p.start = 1'b1;
    i_ppio_host_model.put(p);
    chk(n_starts - s0, 1);
    chk({mot_o.target, pin_o.pos_complete, pin_o.done_pos}, 9'h140);
    p.start = 1'b0;
    p.cmd_pos = 4'h3;
    i_ppio_host_model.put(p);
    chk(mot_o.target, 4'hA);
    mset(M_BUSY, 1'b1, 3);
    p.pause_n = 1'b0;
    i_ppio_host_model.put(p);
    chk({mot_o.hold, pin_o.moving}, 2'h3);
    p.pause_n = 1'b1;
    i_ppio_host_model.put(p);
    chk(mot_o.hold, 1'b0);
    mpulse(M_DONE);
    mset(M_BUSY, 1'b0, 3);
    chk({pin_o.pos_complete, pin_o.done_pos, pin_o.moving}, 6'h34);
    bus(1'b0, PPIO_OFS_STATUS, 32'h0);
    chk(r, 32'h000D_54D5);
    $display("test move done");
  endtask

  task automatic t_stop(input ppio_mot_in_s m, input logic band, input logic push);
    bus(1'b1, PPIO_OFS_CTRL, {31'h0, push});
    mset(M_BAND, band, 2);
    mset(m, 1'b1, 4);
    chk({pin_o.estop_ok, pin_o.pos_complete, pin_o.done_pos}, {~m.estop, 5'h00});
    chk(pin_o.home_done, 1'b1);
    mset(m, 1'b0, 4);
    chk({pin_o.estop_ok, pin_o.pos_complete}, 2'h3);
    chk(pin_o.done_pos, (band && !push) ? 4'hA : 4'h0);
    $display("test stop done");
  endtask

  task automatic t_alarm();
    bus(1'b1, PPIO_OFS_POS_VALID, 32'h0000FFF7);
    s0 = n_starts;
    p.cmd_pos = 4'h3;
    p.start = 1'b1;
    i_ppio_host_model.put(p);
    p.start = 1'b0;
    i_ppio_host_model.put(p);
    chk(n_starts - s0, 0);
    chk(pin_o.alarm_ok, 1'b0);
    bus(1'b0, PPIO_OFS_ALARM, 32'h0);
    chk(r[11:0], PPIO_ALM_NO_DATA);
    reset_pin();
    chk(pin_o.alarm_ok, 1'b1);
    mset(M_FAULT, 1'b1, 3);
    chk(pin_o.alarm_ok, 1'b0);
    reset_pin();
    chk(pin_o.alarm_ok, 1'b0);
    mset(M_FAULT, 1'b0, 3);
    reset_pin();
    chk(pin_o.alarm_ok, 1'b1);
    bus(1'b1, PPIO_OFS_POS_VALID, 32'h0000FFFF);
    $display("test alarm done");
  endtask

  task automatic t_cancel();
    p.cmd_pos = 4'h6;
    p.start = 1'b1;
    i_ppio_host_model.put(p);
    mset(M_BUSY, 1'b1, 2);
    p.start = 1'b0;
    p.pause_n = 1'b0;
    i_ppio_host_model.put(p);
    s0 = n_cancels;
    reset_pin();
    chk(n_cancels - s0, 1);
    chk(pin_o.pos_complete, 1'b1);
    chk(pin_o.done_pos, 4'hA);
    mset(M_BUSY, 1'b0, 2);
    p.pause_n = 1'b1;
    i_ppio_host_model.put(p);
    mpulse(M_OVER);
    reset_pin();
    chk(pin_o.alarm_ok, 1'b0);
    do_reset();
    chk(pin_o.alarm_ok, 1'b1);
    $display("test cancel done");
  endtask

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    t_power_up();
    t_move();
    t_stop(M_STOP, 1'b1, 1'b0);
    t_stop(M_TEACH, 1'b0, 1'b0);
    t_stop(M_STOP, 1'b1, 1'b1);
    t_alarm();
    t_cancel();
    complete_run();
  end
endmodule
